// [shared/ssd_pkg.sv]
// Notes on behaviour
// RL1 - rate divider divides its selected clock by the 16-bit divisor from two bytes
// RL2 - software programs a divisor between 2 and 65535 for the divider to run
// RL3 - writing either divisor byte loads the new divisor into the counter at once
// RL4 - divisor 0 or 1 holds the rate divider stopped
// RL5 - sync enable clear ignores both sync control registers; set applies them
// RL6 - rx data invert flips only received data; no effect in loopback
// RL7 - rx clock edge select: 0 samples on rising edge, 1 on falling edge
// RL8 - with carrier gating on, receive clock reaches receiver only while carrier active
// RL9 - carrier polarity: 0 active low, 1 active high; affects only gating
// RL10 - input disable set ignores data, receive clock and carrier inputs, except that echo mode still forwards them
// RL11 - tx data invert flips only transmitted data; no effect in loopback
// RL12 - idle data output is high when idle level bit 0, low when 1
// RL13 - tx clock edge select: 0 active rising, 1 active falling
// RL14 - idle clock output is high when idle level bit 0, low when 1
// RL15 - send request active just before first tx clock edge until after last
// RL16 - first bit strobe high while first frame bit is on data output; the code raises it only when B_HS_EN is set
// RL17 - send request polarity: 0 active low, 1 active high; ignored in loopback
// RL18 - output tristate bit releases data, clock and send request outputs
// RL19 - echo mode forwards input pins to outputs ignoring every polarity bit
// RL20 - echo mode drives data output from data input, transmitter disconnected
// RL21 - loopback holds data output high and feeds transmit bits to receiver
// RL22 - divider source 0 uses internal clock, 1 the external receive clock
// RL23 - don't care register bits are ignored on write and affect nothing
package ssd_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_DIV_HIGH = 8'hfc;
  localparam logic [7:0] IDX_DIV_LOW = 8'hfd;
  localparam logic [7:0] IDX_SYNC_IN = 8'hfe;
  localparam logic [7:0] IDX_SYNC_OUT = 8'hff;
  localparam logic [7:0] IDX_MODE = 8'hf8;
  localparam logic [7:0] IDX_TX_DATA = 8'hf9;
  localparam logic [7:0] IDX_RX_DATA = 8'hfa;
  localparam logic [7:0] IDX_STATUS = 8'hfb;
  localparam int ADDR_W = 10;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] SYNC_IN_RESET = 8'h03;
  localparam logic [7:0] SYNC_OUT_RESET = 8'h01;
  localparam logic [7:0] SYNC_IN_MASK = 8'hfc;
  localparam logic [7:0] SYNC_OUT_MASK = 8'hfe;
  localparam int B_SYNC_EN = 7;
  localparam int B_RX_INV = 6;
  localparam int B_RX_EDGE = 5;
  localparam int B_CAR_GATE = 4;
  localparam int B_CAR_POL = 3;
  localparam int B_IN_DIS = 2;
  localparam int B_TX_INV = 7;
  localparam int B_TX_IDLE = 6;
  localparam int B_TXC_EDGE = 5;
  localparam int B_TXC_IDLE = 4;
  localparam int B_HS_EN = 3;
  localparam int B_REQ_POL = 2;
  localparam int B_OUT_TRI = 1;
  localparam int B_ECHO = 2;
  localparam int B_LOOP = 1;
  localparam int B_DIV_SRC = 0;
  localparam int B_ST_TX_BUSY = 0;
  localparam int B_ST_RX_FULL = 1;
  localparam int B_ST_DIV_RUN = 2;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // pin bundles and transmitter states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic serial_data_in;
    logic receive_clock_in;
    logic carrier_detect_in;
  } ssd_pins_in_t;

  typedef struct packed {
    logic serial_data_out;
    logic serial_data_out_oe;
    logic transmit_clock_out;
    logic transmit_clock_out_oe;
    logic send_request_out;
    logic send_request_out_oe;
    logic first_bit_strobe;
  } ssd_pins_out_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LEAD = 2'b01,
    TX_BITS = 2'b10
  } ssd_tx_state_t;

endpackage : ssd_pkg

// [design/ssd_sync_io.sv]
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ssd_sync_io
  import ssd_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  input wire ssd_pins_in_t pins_in,
  output ssd_pins_out_t pins_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] s1, s2, s3;
    logic [2:0] filt;
    logic rxc_prev;
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] div_high, div_low, sync_in, sync_out, mode;
    logic [15:0] count;
    logic [7:0] tx_shift;
    logic [3:0] tx_left;
    logic tx_phase;
    ssd_tx_state_t tx_state;
    logic [7:0] rx_shift;
    logic [3:0] rx_count;
    logic [7:0] rx_data;
    logic rx_full;
  } ssd_state_t;

  ssd_state_t st, next_st;

  // map a byte address onto a register index
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = reg_index(a);
    mapped = (a[1:0] == 2'h0) && ((i >= IDX_MODE) && (i <= IDX_SYNC_OUT));
  endfunction : mapped

  // ---------------------------------------------------------------
  // effective configuration
  // ---------------------------------------------------------------
  logic sync_en, echo, loop, ext_src;
  logic [7:0] sin_cfg, serial_data_out_cfg;
  logic [15:0] divisor;
  logic div_run, src_tick, tick;
  logic din_raw, din_rx, rxc, car, car_active, rxc_edge;
  logic tx_bit, tx_active_edge;
  logic aw_take, w_take, ar_take, do_write;
  logic [7:0] wr_idx;

  assign sync_en = st.sync_in[B_SYNC_EN];
  assign sin_cfg = sync_en ? (st.sync_in & SYNC_IN_MASK) : 8'h00; // RL5 RL23
  assign serial_data_out_cfg = sync_en ? (st.sync_out & SYNC_OUT_MASK) : 8'h00; // RL5 RL23
  assign echo = st.mode[B_ECHO];
  assign loop = st.mode[B_LOOP];
  assign ext_src = st.mode[B_DIV_SRC];
  assign divisor = {st.div_high, st.div_low}; // RL1
  assign div_run = divisor >= DIV_MIN; // RL4

  // filtered pins, ignored when inputs are disabled
  assign din_raw = sin_cfg[B_IN_DIS] ? 1'b1 : st.filt[2]; // RL10
  assign rxc = sin_cfg[B_IN_DIS] ? 1'b0 : st.filt[1]; // RL10
  assign car = sin_cfg[B_IN_DIS] ? 1'b0 : st.filt[0]; // RL10
  assign car_active = sin_cfg[B_CAR_POL] ? car : ~car; // RL9

  // divider source ticks
  assign src_tick = ext_src ? (rxc & ~st.rxc_prev) : 1'b1; // RL22
  assign tick = div_run && src_tick && (st.count <= 16'h0001);

  // transmit clock edge in the middle of each bit is the active one
  assign tx_bit = st.tx_shift[0];
  assign tx_active_edge = tick && (st.tx_state == TX_BITS) && !st.tx_phase;

  // receiver data and sampling edge
  assign din_rx = loop ? tx_bit : (din_raw ^ sin_cfg[B_RX_INV]); // RL6 RL21
  always_comb begin
    if (loop) begin
      rxc_edge = tx_active_edge; // RL21
    end else if (sin_cfg[B_CAR_GATE] && !car_active) begin
      rxc_edge = 1'b0; // RL8
    end else if (sin_cfg[B_RX_EDGE]) begin
      rxc_edge = ~rxc & st.rxc_prev; // RL7
    end else begin
      rxc_edge = rxc & ~st.rxc_prev; // RL7
    end
  end

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  assign s_axi_awready = ce && !st.aw_held && !st.bvalid;
  assign s_axi_wready = ce && !st.w_held && !st.bvalid;
  assign s_axi_arready = ce && !st.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = st.aw_held && st.w_held && !st.bvalid;
  assign wr_idx = reg_index(st.aw_addr);
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic wr_en;
    rd_idx = reg_index(s_axi_araddr);
    rd_val = 8'h00;
    wr_en = do_write && st.w_lane0 && mapped(st.aw_addr);
    next_st = st;

    // three-stage pin synchroniser, value taken when stages two and three agree
    next_st.s1 = {pins_in.serial_data_in, pins_in.receive_clock_in,
                  pins_in.carrier_detect_in};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 3; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    next_st.rxc_prev = rxc;

    // write address and data taken in either order
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // rate divider counts down from the divisor
    if (!div_run) begin
      next_st.count = divisor; // RL4
    end else if (src_tick) begin
      next_st.count = (st.count <= 16'h0001) ? divisor : st.count - 16'h0001; // RL1
    end

    // transmitter: lead tick for send request, then two ticks per bit
    if (tick) begin
      case (st.tx_state)
        TX_LEAD: begin
          next_st.tx_state = TX_BITS; // RL15
          next_st.tx_phase = 1'b0;
        end
        TX_BITS: begin
          next_st.tx_phase = ~st.tx_phase;
          if (st.tx_phase) begin
            next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
            next_st.tx_left = st.tx_left - 4'h1;
            if (st.tx_left == 4'h1) begin
              next_st.tx_state = TX_IDLE; // RL15
            end
          end
        end
        default: begin
          next_st.tx_state = st.tx_state;
        end
      endcase
    end

    // receiver shifts lsb first, eight bits per word
    if (rxc_edge) begin
      next_st.rx_shift = {din_rx, st.rx_shift[7:1]};
      if (st.rx_count == FRAME_BITS - 4'h1) begin
        next_st.rx_count = 4'h0;
        next_st.rx_data = {din_rx, st.rx_shift[7:1]};
      end else begin
        next_st.rx_count = st.rx_count + 4'h1;
      end
    end

    // register writes
    if (wr_en) begin
      case (wr_idx)
        IDX_DIV_HIGH: begin
          next_st.div_high = st.w_data;
          next_st.count = {st.w_data, st.div_low}; // RL3
        end
        IDX_DIV_LOW: begin
          next_st.div_low = st.w_data;
          next_st.count = {st.div_high, st.w_data}; // RL3
        end
        IDX_SYNC_IN: next_st.sync_in = st.w_data & SYNC_IN_MASK; // RL23
        IDX_SYNC_OUT: next_st.sync_out = st.w_data & SYNC_OUT_MASK; // RL23
        IDX_MODE: next_st.mode = st.w_data & 8'h07;
        IDX_TX_DATA: begin
          if (st.tx_state == TX_IDLE && div_run) begin
            next_st.tx_shift = st.w_data;
            next_st.tx_left = FRAME_BITS;
            next_st.tx_state = TX_LEAD;
          end
        end
        IDX_STATUS: begin
          if (st.w_data[B_ST_RX_FULL]) begin
            next_st.rx_full = 1'b0;
          end
        end
        default: begin
          next_st.mode = st.mode;
        end
      endcase
    end

    // a finished word sets the flag even when cleared in the same cycle
    if (rxc_edge && st.rx_count == FRAME_BITS - 4'h1) begin
      next_st.rx_full = 1'b1;
    end

    // register reads
    case (rd_idx)
      IDX_DIV_HIGH: rd_val = st.div_high;
      IDX_DIV_LOW: rd_val = st.div_low;
      IDX_SYNC_IN: rd_val = st.sync_in;
      IDX_SYNC_OUT: rd_val = st.sync_out;
      IDX_MODE: rd_val = st.mode;
      IDX_RX_DATA: rd_val = st.rx_data;
      IDX_STATUS: begin
        rd_val[B_ST_TX_BUSY] = st.tx_state != TX_IDLE;
        rd_val[B_ST_RX_FULL] = st.rx_full;
        rd_val[B_ST_DIV_RUN] = div_run;
      end
      default: rd_val = 8'h00;
    endcase
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = {24'h000000, rd_val};
      next_st.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.sync_in <= SYNC_IN_RESET;
      st.sync_out <= SYNC_OUT_RESET;
      st.tx_state <= TX_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // output pins
  // ---------------------------------------------------------------
  always_comb begin
    logic busy, req_active, clk_level;
    busy = st.tx_state == TX_BITS;
    req_active = st.tx_state != TX_IDLE;
    // active edge comes at mid bit: rising means low then high
    clk_level = st.tx_phase ^ serial_data_out_cfg[B_TXC_EDGE]; // RL13
    pins_out = '0;
    if (echo) begin
      pins_out.serial_data_out = st.filt[2]; // RL19 RL20
      pins_out.transmit_clock_out = st.filt[1]; // RL19
      pins_out.send_request_out = st.filt[0]; // RL19
    end else begin
      if (loop) begin
        pins_out.serial_data_out = 1'b1; // RL21
      end else if (busy) begin
        pins_out.serial_data_out = tx_bit ^ serial_data_out_cfg[B_TX_INV]; // RL11
      end else begin
        pins_out.serial_data_out = ~serial_data_out_cfg[B_TX_IDLE]; // RL12
      end
      pins_out.transmit_clock_out = busy ? clk_level
                                         : ~serial_data_out_cfg[B_TXC_IDLE]; // RL14
      if (loop || !serial_data_out_cfg[B_HS_EN]) begin
        pins_out.send_request_out = 1'b1; // RL17
      end else begin
        pins_out.send_request_out = req_active ~^ serial_data_out_cfg[B_REQ_POL]; // RL15 RL17
      end
    end
    pins_out.first_bit_strobe = serial_data_out_cfg[B_HS_EN] && busy &&
                                (st.tx_left == FRAME_BITS); // RL16
    pins_out.serial_data_out_oe = !serial_data_out_cfg[B_OUT_TRI]; // RL18
    pins_out.transmit_clock_out_oe = !serial_data_out_cfg[B_OUT_TRI]; // RL18
    pins_out.send_request_out_oe = !serial_data_out_cfg[B_OUT_TRI]; // RL18
  end

endmodule : ssd_sync_io

// [verif/ssd_sync_io_props.sv]
`timescale 1ns/1ps
module ssd_sync_io_props
  import ssd_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  input wire ssd_pins_out_t pins_out
);
  // ------------------------------------------
  // bus and pin properties
  // ------------------------------------------
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // answers stand until taken
  chk_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // read answered the cycle after its address is taken
  chk_read_next: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while busy");
  // enable low stalls the bus and freezes the pins
  chk_ce_stall: assert property (!ce |->
    !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready while stalled");
  chk_ce_freeze: assert property (!ce |=> $stable(pins_out))
    else $error("pins moved while stalled");
  // pins leave reset idle high and driven
  chk_reset_idle: assert property (!$past(aresetn) |->
    pins_out == 7'h7e) else $error("pins not idle after reset");
  // the three outputs are released together
  chk_oe_group: assert property (
    pins_out.serial_data_out_oe == pins_out.transmit_clock_out_oe &&
    pins_out.send_request_out_oe == pins_out.transmit_clock_out_oe)
    else $error("output enables disagree");
  // main scenarios
  cov_frame: cover property ($rose(pins_out.first_bit_strobe));
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_stall: cover property (!ce);
endmodule : ssd_sync_io_props

bind ssd_sync_io ssd_sync_io_props chk_i (.*);

// [verif/ssd_far_end.sv]
`timescale 1ns/1ps
module ssd_far_end
  import ssd_pkg::*;
(
  // bench control
  input wire logic aclk,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic car_act,
  input wire logic cap_fall,
  input wire logic cap_clear,
  // pins
  input wire ssd_pins_out_t pins_out,
  output ssd_pins_in_t pins_in,
  output logic [7:0] cap_byte,
  output logic [3:0] cap_count
);
  logic last_clk;

  // idle: clock still, carrier inactive
  initial pins_in = 3'b101;

  // one frame; rising edge sees the bit, falling edge its inverse
  always @(posedge send) begin
    pins_in.carrier_detect_in <= car_act;
    for (int i = 0; i < 8; i++) begin
      pins_in.serial_data_in <= send_byte[i];
      repeat (4) @(posedge aclk);
      pins_in.receive_clock_in <= 1'b1;
      repeat (4) @(posedge aclk);
      pins_in.serial_data_in <= !send_byte[i];
      repeat (4) @(posedge aclk);
      pins_in.receive_clock_in <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    pins_in.carrier_detect_in <= !car_act;
  end

  // sample data out on the chosen edge of the transmit clock
  always @(posedge aclk) begin
    last_clk <= pins_out.transmit_clock_out;
    if (cap_clear) begin
      cap_count <= 4'h0;
    end else if (last_clk !== pins_out.transmit_clock_out &&
        pins_out.transmit_clock_out === !cap_fall && cap_count < 8) begin
      cap_byte <= {pins_out.serial_data_out, cap_byte[7:1]};
      cap_count <= cap_count + 4'h1;
    end
  end
endmodule : ssd_far_end

// [verif/serial_sync_io_and_baud_divider_bench.sv]
`timescale 1ns/1ps
module serial_sync_io_and_baud_divider_bench
  import ssd_pkg::*;
;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = '0, cap_count;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, e;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  ssd_pins_in_t pins_in;
  ssd_pins_out_t pins_out;
  logic send = 1'b0, car_act = 1'b0, cap_fall = 1'b0, cap_clear = 1'b0;
  logic [7:0] send_byte = '0, cap_byte, b;
  logic [7:0] so_tab [4] = '{8'h0c, 8'h8c, 8'h28, 8'h5c};
  logic [7:0] si_tab [6] = '{8'h80, 8'hc0, 8'ha0, 8'h98, 8'h90, 8'h84};
  logic [15:0] d;
  int fail_count = 0, total_checks = 0;

  ssd_sync_io uut (.*);
  ssd_far_end far (.*);

  // 50 mhz clock
  always #10 aclk = !aclk;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] rx_exp(input logic [7:0] v, si);
    return v ^ {8{si[B_RX_INV] ^ si[B_RX_EDGE]}};
  endfunction : rx_exp

  // one write, address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // one transmitted frame, with a stall in mid-frame
  task automatic tx_case(input logic [7:0] so, md);
    int k;
    b = 8'($urandom);
    wr(IDX_SYNC_OUT, so);
    wr(IDX_MODE, md);
    cap_fall <= so[B_TXC_EDGE];
    cap_clear <= 1'b1;
    @(posedge aclk);
    cap_clear <= 1'b0;
    wr(IDX_TX_DATA, b);
    for (k = 0; k < 99 && pins_out.first_bit_strobe !== 1'b1; k++)
      @(posedge aclk);
    e = md[B_LOOP] | (b[0] ^ so[B_TX_INV]);
    chk("strobe", pins_out.first_bit_strobe, 1'b1);
    chk("bit0", pins_out.serial_data_out, e);
    if (!md[B_LOOP])
      chk("rts on", pins_out.send_request_out, so[B_REQ_POL]);
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    for (k = 0; k < 20; k++) begin
      rd(IDX_STATUS);
      if (rv[B_ST_TX_BUSY] === 1'b0) break;
    end
    if (md[B_LOOP]) begin
      rd(IDX_RX_DATA);
      chk("loop rx", rv, b);
    end else begin
      chk("bits", cap_count, 4'h8);
      chk("tx byte", cap_byte, b ^ {8{so[B_TX_INV]}});
      chk("rts off", pins_out.send_request_out, !so[B_REQ_POL]);
      chk("data idle", pins_out.serial_data_out, !so[B_TX_IDLE]);
      chk("clk idle", pins_out.transmit_clock_out, !so[B_TXC_IDLE]);
    end
  endtask : tx_case

  // one frame from the far end into the receiver
  task automatic rx_case(input logic [7:0] si, input logic car, ok);
    b = 8'($urandom);
    wr(IDX_STATUS, 8'h02);
    wr(IDX_SYNC_IN, si);
    car_act <= car;
    send_byte <= b;
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (150) @(posedge aclk);
    rd(IDX_STATUS);
    chk("rx full", rv[B_ST_RX_FULL], ok);
    rd(IDX_RX_DATA);
    if (ok)
      chk("rx byte", rv, rx_exp(b, si));
  endtask : rx_case

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(32'hc438));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk("reset pins", pins_out, 7'h7e);
    rd(IDX_SYNC_IN);
    chk("sync_in reset", rv, 32'h03);
    rd(IDX_SYNC_OUT);
    chk("sync_out reset", rv, 32'h01);
    rd(8'h00);
    chk("unmapped resp", rr, RESP_SLVERR);
    chk("unmapped data", rv, 32'h0);
    wr(8'h00, 8'h55);
    chk("unmapped wresp", br, RESP_SLVERR);
    wr(IDX_SYNC_OUT, 8'h5e);
    chk("write resp", br, RESP_OKAY);
    chk("sync off", pins_out, 7'h7e);
    wr(IDX_SYNC_IN, 8'hff);
    rd(IDX_SYNC_IN);
    chk("dont care", rv, 32'hfc);
    chk("tristate", pins_out[5:1] & 5'h15, 5'h0);
    wr(IDX_SYNC_IN, 8'h80);
    for (int i = 0; i < 4; i++) begin
      // a large last divisor makes a late reload miss the strobe window
      d = (i < 3) ? 16'(i) : 16'($urandom) | 16'h8000;
      wr(IDX_DIV_HIGH, d[15:8]);
      wr(IDX_DIV_LOW, d[7:0]);
      rd(IDX_DIV_HIGH);
      chk("div high", rv, d[15:8]);
      rd(IDX_DIV_LOW);
      chk("div low", rv, d[7:0]);
      rd(IDX_STATUS);
      chk("div run", rv[B_ST_DIV_RUN], d >= DIV_MIN);
    end
    wr(IDX_DIV_HIGH, 8'h00);
    wr(IDX_DIV_LOW, 8'h02);
    foreach (so_tab[i]) tx_case(so_tab[i], 8'h00);
    wr(IDX_SYNC_IN, 8'hc0);
    tx_case(8'h8c, 8'h02);
    // external divider source with no receive clock stalls the frame
    wr(IDX_MODE, 8'h01);
    wr(IDX_TX_DATA, 8'h5a);
    repeat (40) @(posedge aclk);
    rd(IDX_STATUS);
    chk("ext stall", rv[B_ST_TX_BUSY], 1'b1);
    wr(IDX_MODE, 8'h00);
    foreach (si_tab[i]) rx_case(si_tab[i], i == 3 || i == 4, i < 4);
    // echo: pins mirrored whatever the polarity bits say; without echo
    // send request would idle high and data would come out inverted
    wr(IDX_SYNC_OUT, 8'h88);
    wr(IDX_MODE, 8'h04);
    cap_fall <= 1'b0;
    cap_clear <= 1'b1;
    @(posedge aclk);
    cap_clear <= 1'b0;
    rx_case(8'hc0, 1'b1, 1'b1);
    chk("echo byte", cap_byte, b);
    chk("echo rts", pins_out.send_request_out, 1'b0);
    conclude();
  end

  // watchdog: the run needs well under this span
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    conclude();
  end
endmodule : serial_sync_io_and_baud_divider_bench
